// >>> rtl/iobgr_pkg.sv
// Package of constants and types for the I/O board glue register bank
package iobgr_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFF_PORT_A     = 8'h10;
    localparam logic [7:0] OFF_PORT_B     = 8'h11;
    localparam logic [7:0] OFF_PORT_C     = 8'h12;
    localparam logic [7:0] OFF_PORT_CMD   = 8'h13;
    localparam logic [7:0] OFF_BUF_CTRL   = 8'h14;
    localparam logic [7:0] OFF_TRIG_CMD   = 8'h15;
    localparam logic [7:0] OFF_TRIG_EN    = 8'h16;
    localparam logic [7:0] OFF_COS_FLAGS  = 8'h17;
    localparam logic [7:0] OFF_DAC_REF    = 8'h18;
    // ==========================================================
    // Field positions
    localparam int CMD_MODE_SET   = 7;
    localparam int CMD_GA_MODE2   = 6;
    localparam int CMD_GA_MODE1   = 5;
    localparam int CMD_PA_IN      = 4;
    localparam int CMD_PCH_IN     = 3;
    localparam int CMD_GB_MODE    = 2;
    localparam int CMD_PB_IN      = 1;
    localparam int CMD_PCL_IN     = 0;
    localparam int TRIG_ADC_BIT   = 1;
    localparam int TRIG_DAC_BIT   = 0;
    localparam int TST_BIT        = 0;
    localparam int DACREF_BIT     = 0;
    // ==========================================================
    // Reset values and read mask
    localparam logic [7:0] CMD_RESET      = 8'h9B;
    localparam logic [7:0] BYTE_ZERO      = 8'h00;
    localparam logic [7:0] TRIG_CMD_MASK  = 8'h1F;
    // ==========================================================
    // Timing
    localparam int CLK_MHZ         = 200;
    localparam int TICK_PULSE_US   = 1;
    localparam int TICK_PULSE_CYC  = TICK_PULSE_US * CLK_MHZ;

    typedef enum logic [1:0] {
        IOBGR_MODE0 = 2'b00,
        IOBGR_MODE1 = 2'b01,
        IOBGR_MODE2 = 2'b10
    } iobgr_mode_t;

    typedef struct packed {
        logic [7:0] pa;
        logic [7:0] pb;
        logic [7:0] pc;
    } iobgr_ports_t;
endpackage : iobgr_pkg

// >>> rtl/iobgr_top.sv
// Register bank and trigger logic for the multifunction I/O board
`timescale 1ns/1ps
// Function
// - Tick counter mode 2 output gives a 1 us low pulse each period.
// - With ADC tick enable set, each low tick pulse starts one conversion.
// - With DAC tick enable set, each tick updates all DACs together.
// - Triggered ADC command keeps low five bits; upper three read zero.
// - Tick conversions use the stored triggered command, not normal ADC byte.
// - Port read gives pin levels for inputs, latched value for outputs.
// - Command register is write-only; bit7 mode set, 6:5 group A, 2 group B.
// - Bits 4,3,1,0 set A, C upper, B, C lower direction; one is input.
// - Reset leaves mode 0 with all 24 lines as inputs.
// - Buffer directions follow the most recent command direction bits.
// - Bit 6 set selects group A mode 2 and bit 5 is ignored.
// - Buffer control bit 0 enters tristate mode; clearing it leaves.
// - In tristate mode a newly output port has its buffer floated.
// - Same command with bit 7 clear re-enables buffers, directions kept.
// - Change flag bit n sets when Port C bit n toggles since last read.
// - Reading change flags clears them; later toggles collect afresh.
// - DAC reference enable clears on reset; writing one enables it.
// - Port C change also sets board status flag and interrupt when enabled.
// - With DAC tick enable set, DAC writes wait for the next tick.
// - ADC command bit4 range, bit3 bipolar, bits 2:0 channel.
module iobgr_top
    import iobgr_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire logic [7:0]            bus_addr,
    input  wire logic [7:0]            bus_wdata,
    input  wire logic                  bus_wr,
    input  wire logic                  bus_rd,
    output logic      [7:0]            bus_rdata,
    input  wire logic                  tick_n,
    input  wire logic                  dac_write,
    input  wire logic                  cos_irq_enable,
    input  wire iobgr_pkg::iobgr_ports_t pin_in,
    output iobgr_pkg::iobgr_ports_t    pin_out,
    output iobgr_pkg::iobgr_ports_t    pin_oe,
    output logic                       tick_pulse_n,
    output logic                       adc_start,
    output logic      [4:0]            adc_command,
    output logic                       dac_load,
    output logic                       dac_ref_on,
    output logic      [1:0]            group_a_mode,
    output logic                       group_b_mode,
    output logic                       cos_status,
    output logic                       cos_irq
);
    import iobgr_pkg::*;

    // ==========================================================
    // Input synchronisers
    iobgr_ports_t pins_s1_reg;
    iobgr_ports_t pins_s2_reg;
    logic         tick_s1_reg;
    logic         tick_s2_reg;
    logic         tick_d_reg;

    // Both input paths reset to the idle-high level so no false edge follows reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pins_s1_reg <= '1;
            pins_s2_reg <= '1;
        end else begin
            pins_s1_reg <= pin_in;
            pins_s2_reg <= pins_s1_reg;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tick_s1_reg <= 1'b1;
            tick_s2_reg <= 1'b1;
            tick_d_reg  <= 1'b1;
        end else begin
            tick_s1_reg <= tick_n;
            tick_s2_reg <= tick_s1_reg;
            tick_d_reg  <= tick_s2_reg;
        end
    end

    logic tick_fall;
    assign tick_fall = tick_d_reg & ~tick_s2_reg;

    // ==========================================================
    // Register write strobes
    function automatic logic wr_hit(input logic [7:0] off);
        wr_hit = bus_wr && (bus_addr == off);
    endfunction : wr_hit

    // ==========================================================
    // Register state
    logic [7:0] cmd_reg;
    logic       buf_enable_reg;
    logic       tst_reg;
    logic [7:0] out_a_reg;
    logic [7:0] out_b_reg;
    logic [7:0] out_c_reg;
    logic [4:0] trig_cmd_reg;
    logic       trig_adc_reg;
    logic       trig_dac_reg;
    logic       dacref_reg;
    logic [7:0] cos_reg;
    logic [7:0] pc_prev_reg;
    logic       cos_status_reg;

    // ==========================================================
    // Parallel port command and buffers
    // Reset value is all inputs; outputs of the latch start low like the chip
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cmd_reg        <= CMD_RESET;
            buf_enable_reg <= 1'b1;
        end else if (wr_hit(OFF_PORT_CMD)) begin
            cmd_reg[4:0] <= bus_wdata[4:0];
            cmd_reg[7:5] <= bus_wdata[7:5];
            // Mode set write with tristate floats the buffers; bit 7 clear restores
            if (bus_wdata[CMD_MODE_SET])
                buf_enable_reg <= ~tst_reg;
            else
                buf_enable_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            out_a_reg <= BYTE_ZERO;
            out_b_reg <= BYTE_ZERO;
            out_c_reg <= BYTE_ZERO;
        end else begin
            // New mode set clears the output latches, the quirk tristate hides
            if (wr_hit(OFF_PORT_CMD) && bus_wdata[CMD_MODE_SET]) begin
                out_a_reg <= BYTE_ZERO;
                out_b_reg <= BYTE_ZERO;
                out_c_reg <= BYTE_ZERO;
            end
            if (wr_hit(OFF_PORT_A))
                out_a_reg <= bus_wdata;
            if (wr_hit(OFF_PORT_B))
                out_b_reg <= bus_wdata;
            if (wr_hit(OFF_PORT_C))
                out_c_reg <= bus_wdata;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            tst_reg <= 1'b0;
        else if (wr_hit(OFF_BUF_CTRL))
            tst_reg <= bus_wdata[TST_BIT];
    end

    logic [7:0] dir_out_a;
    logic [7:0] dir_out_b;
    logic [7:0] dir_out_c;
    assign dir_out_a = {8{~cmd_reg[CMD_PA_IN]}};
    assign dir_out_b = {8{~cmd_reg[CMD_PB_IN]}};
    assign dir_out_c = {{4{~cmd_reg[CMD_PCH_IN]}}, {4{~cmd_reg[CMD_PCL_IN]}}};

    // Buffers float after a tristate mode set until a bit 7 clear write or a mode set with tristate off
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_out <= '0;
            pin_oe  <= '0;
        end else begin
            pin_out.pa <= out_a_reg;
            pin_out.pb <= out_b_reg;
            pin_out.pc <= out_c_reg;
            pin_oe.pa  <= dir_out_a & {8{buf_enable_reg}};
            pin_oe.pb  <= dir_out_b & {8{buf_enable_reg}};
            pin_oe.pc  <= dir_out_c & {8{buf_enable_reg}};
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            group_a_mode <= IOBGR_MODE0;
            group_b_mode <= 1'b0;
        end else begin
            if (cmd_reg[CMD_GA_MODE2])
                group_a_mode <= IOBGR_MODE2;
            else if (cmd_reg[CMD_GA_MODE1])
                group_a_mode <= IOBGR_MODE1;
            else
                group_a_mode <= IOBGR_MODE0;
            group_b_mode <= cmd_reg[CMD_GB_MODE];
        end
    end

    // ==========================================================
    // Trigger registers and tick path
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            trig_cmd_reg <= '0;
        else if (wr_hit(OFF_TRIG_CMD))
            trig_cmd_reg <= bus_wdata[4:0];
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            trig_adc_reg <= 1'b0;
            trig_dac_reg <= 1'b0;
        end else if (wr_hit(OFF_TRIG_EN)) begin
            trig_adc_reg <= bus_wdata[TRIG_ADC_BIT];
            trig_dac_reg <= bus_wdata[TRIG_DAC_BIT];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            dacref_reg <= 1'b0;
        else if (wr_hit(OFF_DAC_REF))
            dacref_reg <= bus_wdata[DACREF_BIT];
    end

    // Tick pulse regenerated at a fixed 1 us width on each falling edge
    logic [$clog2(TICK_PULSE_CYC+1)-1:0] pulse_cnt_reg;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pulse_cnt_reg <= '0;
            tick_pulse_n  <= 1'b1;
        end else if (tick_fall) begin
            pulse_cnt_reg <= ($clog2(TICK_PULSE_CYC+1))'(TICK_PULSE_CYC - 1);
            tick_pulse_n  <= 1'b0;
        end else if (pulse_cnt_reg != '0) begin
            pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
        end else begin
            tick_pulse_n  <= 1'b1;
        end
    end

    // ==========================================================
    // Trigger outputs
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            adc_start   <= 1'b0;
            adc_command <= '0;
        end else begin
            adc_start   <= tick_fall & trig_adc_reg;
            adc_command <= trig_cmd_reg;
        end
    end

    // Direct DAC writes load at once only while tick updates are off
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            dac_load <= 1'b0;
        else
            dac_load <= trig_dac_reg ? tick_fall : dac_write;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            dac_ref_on <= 1'b0;
        else
            dac_ref_on <= dacref_reg;
    end

    // ==========================================================
    // Port C change-of-state
    logic       cos_rd;
    logic [7:0] pc_toggle;
    assign cos_rd    = bus_rd && (bus_addr == OFF_COS_FLAGS);
    assign pc_toggle = pins_s2_reg.pc ^ pc_prev_reg;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            pc_prev_reg <= '1;
        else
            pc_prev_reg <= pins_s2_reg.pc;
    end

    // A toggle on the read edge is kept for the next read, not returned twice
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            cos_reg <= '0;
        else if (cos_rd)
            cos_reg <= pc_toggle;
        else
            cos_reg <= cos_reg | pc_toggle;
    end

    // A change in the clearing cycle wins, so no event is lost
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            cos_status_reg <= 1'b0;
        else if (pc_toggle != '0)
            cos_status_reg <= 1'b1;
        else if (bus_wr && (bus_addr == BYTE_ZERO))
            cos_status_reg <= 1'b0;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            cos_status <= 1'b0;
        else
            cos_status <= cos_status_reg;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            cos_irq <= 1'b0;
        else
            cos_irq <= cos_status_reg & cos_irq_enable;
    end

    // ==========================================================
    // Read mux
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = BYTE_ZERO;
        if (bus_addr == OFF_PORT_A)
            rd_mux = (out_a_reg & dir_out_a) | (pins_s2_reg.pa & ~dir_out_a);
        else if (bus_addr == OFF_PORT_B)
            rd_mux = (out_b_reg & dir_out_b) | (pins_s2_reg.pb & ~dir_out_b);
        else if (bus_addr == OFF_PORT_C)
            rd_mux = (out_c_reg & dir_out_c) | (pins_s2_reg.pc & ~dir_out_c);
        else if (bus_addr == OFF_BUF_CTRL)
            rd_mux = {7'h00, tst_reg};
        else if (bus_addr == OFF_TRIG_CMD)
            rd_mux = {3'h0, trig_cmd_reg} & TRIG_CMD_MASK;
        else if (bus_addr == OFF_TRIG_EN)
            rd_mux = {6'h00, trig_adc_reg, trig_dac_reg};
        else if (bus_addr == OFF_COS_FLAGS)
            rd_mux = cos_reg;
        else if (bus_addr == OFF_DAC_REF)
            rd_mux = {7'h00, dacref_reg};
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            bus_rdata <= BYTE_ZERO;
        else if (bus_rd)
            bus_rdata <= rd_mux;
    end
endmodule : iobgr_top

// >>> verification/iobgr_top_assertions.sv
// Port-level concurrent checks for the I/O board glue register bank
`timescale 1ns/1ps
module iobgr_chk
    import iobgr_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic       bus_wr,
    input wire logic       bus_rd,
    input wire logic [7:0] bus_rdata,
    input wire logic       cos_irq_enable,
    input wire logic       tick_pulse_n,
    input wire logic       adc_start,
    input wire logic       dac_ref_on,
    input wire logic [1:0] group_a_mode,
    input wire logic       group_b_mode,
    input wire logic       cos_status,
    input wire logic       cos_irq
);
    // ==========================================================
    // Helper: length of the low tick pulse, too long to unroll
    logic [8:0] low_cnt_reg;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            low_cnt_reg <= 9'h000;
        end else if (tick_pulse_n) begin
            low_cnt_reg <= 9'h000;
        end else begin
            low_cnt_reg <= low_cnt_reg + 9'h001;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // ==========================================================
    // Checks
    chk_tick_width: assert property ($rose(tick_pulse_n) |-> low_cnt_reg == TICK_PULSE_CYC)
        else $error("tick pulse width wrong");
    chk_adc_on_tick: assert property (adc_start |-> $fell(tick_pulse_n))
        else $error("conversion start without tick");
    chk_adc_one_shot: assert property (adc_start |=> !adc_start)
        else $error("conversion start longer than one cycle");
    chk_cmd_reads_zero: assert property (bus_rd && bus_addr == OFF_PORT_CMD |=> bus_rdata == BYTE_ZERO)
        else $error("command register readable");
    chk_trig_cmd_top: assert property (bus_rd && bus_addr == OFF_TRIG_CMD |=> bus_rdata[7:5] == 3'h0)
        else $error("triggered command top bits not zero");
    chk_unused_zero: assert property (bus_rd && (bus_addr == OFF_BUF_CTRL || bus_addr == OFF_DAC_REF)
        |=> bus_rdata[7:1] == 7'h00)
        else $error("unused bits read nonzero");
    chk_dac_ref_write: assert property (bus_wr && bus_addr == OFF_DAC_REF
        |-> ##2 dac_ref_on == $past(bus_wdata[DACREF_BIT], 2))
        else $error("reference enable not written");
    chk_group_modes: assert property (bus_wr && bus_addr == OFF_PORT_CMD && bus_wdata[CMD_MODE_SET]
        |-> ##2 group_b_mode == $past(bus_wdata[CMD_GB_MODE], 2) && group_a_mode ==
        ($past(bus_wdata[CMD_GA_MODE2], 2) ? 2'b10 : {1'b0, $past(bus_wdata[CMD_GA_MODE1], 2)}))
        else $error("group modes wrong after mode set");
    chk_cos_irq: assert property (cos_irq == (cos_status && $past(cos_irq_enable)))
        else $error("change interrupt wrong");
endmodule : iobgr_chk

bind iobgr_top iobgr_chk u_chk (.clk_sys(clk_sys), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .cos_irq_enable(cos_irq_enable),
    .tick_pulse_n(tick_pulse_n), .adc_start(adc_start), .dac_ref_on(dac_ref_on),
    .group_a_mode(group_a_mode), .group_b_mode(group_b_mode), .cos_status(cos_status), .cos_irq(cos_irq));

// >>> verification/iobgr_pin_env.sv
// Model of the field wiring on the 24 digital lines, with board pull-ups
`timescale 1ns/1ps
module iobgr_pin_env
    import iobgr_pkg::*;
(
    input  wire iobgr_pkg::iobgr_ports_t pin_out,
    input  wire iobgr_pkg::iobgr_ports_t pin_oe,
    input  wire iobgr_pkg::iobgr_ports_t ext_val,
    input  wire iobgr_pkg::iobgr_ports_t ext_en,
    output iobgr_pkg::iobgr_ports_t      pin_in
);
    // ==========================================================
    // Undriven lines float up; field drive is only enabled on input ports
    assign pin_in = iobgr_ports_t'((pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en));
endmodule : iobgr_pin_env

// >>> verification/io_board_glue_registers_test.sv
// Self-checking bench for the I/O board glue register bank
`timescale 1ns/1ps
module io_board_glue_registers_test;
    import iobgr_pkg::*;
    logic         clk_sys = 1'b0;
    logic         rst = 1'b1;
    logic [7:0]   bus_addr = 8'h00;
    logic [7:0]   bus_wdata = 8'h00;
    logic         bus_wr = 1'b0;
    logic         bus_rd = 1'b0;
    logic         tick_n = 1'b1;
    logic         dac_write = 1'b0;
    logic         cos_irq_enable = 1'b0;
    iobgr_ports_t ext_val = '0;
    iobgr_ports_t ext_en = '0;
    iobgr_ports_t pin_in, pin_out, pin_oe;
    logic [7:0]   bus_rdata;
    logic [4:0]   adc_command;
    logic [1:0]   group_a_mode;
    logic         tick_pulse_n, adc_start, dac_load, dac_ref_on, group_b_mode, cos_status, cos_irq;
    int           fail_count = 0;
    int           num_checks = 0;
    int           cyc = 0;
    int           adc_seen = 0;
    int           dac_seen = 0;
    iobgr_top uut (.clk_sys, .rst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .tick_n, .dac_write,
        .cos_irq_enable, .pin_in, .pin_out, .pin_oe, .tick_pulse_n, .adc_start, .adc_command, .dac_load,
        .dac_ref_on, .group_a_mode, .group_b_mode, .cos_status, .cos_irq);
    iobgr_pin_env u_env (.pin_out, .pin_oe, .ext_val, .ext_en, .pin_in);
    always #2.5 clk_sys = ~clk_sys;
    // ==========================================================
    // Event counting and hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (adc_start === 1'b1) adc_seen++;
        if (dac_load === 1'b1) dac_seen++;
        if (cyc == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    // ==========================================================
    // Shared tasks
    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // Idle cycles after a write let the pin effects and the input synchroniser settle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
    endtask : wr
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1;
        chk(what, {16'h0000, bus_rdata}, {16'h0000, exp});
    endtask : rd_chk
    task automatic pulse_tick;
        @(posedge clk_sys);
        tick_n <= 1'b0;
        repeat (TICK_PULSE_CYC) @(posedge clk_sys);
        tick_n <= 1'b1;
        repeat (220) @(posedge clk_sys);
        #1;
    endtask : pulse_tick
    task automatic pulse_dac;
        @(posedge clk_sys);
        dac_write <= 1'b1;
        @(posedge clk_sys);
        dac_write <= 1'b0;
        repeat (6) @(posedge clk_sys);
        #1;
    endtask : pulse_dac
    task automatic set_pc(input logic [7:0] v);
        @(posedge clk_sys);
        ext_val.pc <= v;
        repeat (8) @(posedge clk_sys);
    endtask : set_pc
    // ==========================================================
    // Scenarios
    task automatic t_reset_regs;
        chk("oe", pin_oe, 24'h000000);
        chk("modes", {group_a_mode, group_b_mode}, 24'h000000);
        chk("ref", dac_ref_on, 24'h000000);
        rd_chk("pa", OFF_PORT_A, 8'hFF);
        wr(OFF_BUF_CTRL, 8'hFF);
        rd_chk("buf", OFF_BUF_CTRL, 8'h01);
        wr(OFF_TRIG_EN, 8'hFF);
        rd_chk("trig_en", OFF_TRIG_EN, 8'h03);
        wr(OFF_TRIG_CMD, 8'hFF);
        rd_chk("trig_cmd", OFF_TRIG_CMD, 8'h1F);
        wr(OFF_DAC_REF, 8'hFE);
        rd_chk("ref_reg", OFF_DAC_REF, 8'h00);
        chk("ref", dac_ref_on, 24'h000000);
        rd_chk("cmd", OFF_PORT_CMD, 8'h00);
        rd_chk("unmapped", 8'h30, 8'h00);
        wr(OFF_TRIG_EN, 8'h00);
        wr(OFF_BUF_CTRL, 8'h00);
    endtask : t_reset_regs
    task automatic t_ports;
        logic [7:0] cmds[3] = '{8'hE4, 8'hA0, 8'h80};
        logic [2:0] modes[3] = '{3'b101, 3'b010, 3'b000};
        for (int i = 0; i < 3; i++) begin
            wr(OFF_PORT_CMD, cmds[i]);
            chk("modes", {group_a_mode, group_b_mode}, modes[i]);
        end
        chk("oe", pin_oe, 24'hFFFFFF);
        wr(OFF_PORT_A, 8'h5A);
        wr(OFF_PORT_B, 8'hC3);
        wr(OFF_PORT_C, 8'h0F);
        chk("out", pin_out, 24'h5AC30F);
        rd_chk("pb", OFF_PORT_B, 8'hC3);
        wr(OFF_PORT_CMD, 8'h98);
        chk("oe", pin_oe, 24'h00FF0F);
        rd_chk("pa", OFF_PORT_A, 8'hFF);
    endtask : t_ports
    task automatic t_tristate;
        wr(OFF_BUF_CTRL, 8'h01);
        wr(OFF_PORT_CMD, 8'h89);
        chk("oe", pin_oe, 24'h000000);
        wr(OFF_PORT_A, 8'hAA);
        wr(OFF_PORT_B, 8'h55);
        wr(OFF_PORT_CMD, 8'h09);
        chk("oe", pin_oe, 24'hFFFF00);
        chk("out", pin_out, 24'hAA5500);
        wr(OFF_BUF_CTRL, 8'h00);
        wr(OFF_PORT_CMD, 8'h80);
        chk("oe", pin_oe, 24'hFFFFFF);
    endtask : t_tristate
    task automatic t_cos;
        wr(OFF_PORT_CMD, 8'h9B);
        @(posedge clk_sys);
        ext_val <= '1;
        ext_en <= '1;
        repeat (6) @(posedge clk_sys);
        #1;
        rd_chk("cos", OFF_COS_FLAGS, 8'hFF);
        set_pc(8'h50);
        rd_chk("cos", OFF_COS_FLAGS, 8'hAF);
        wr(8'h00, 8'h00);
        @(posedge clk_sys);
        cos_irq_enable <= 1'b1;
        set_pc(8'h40);
        set_pc(8'h60);
        #1;
        chk("status", {cos_status, cos_irq}, 24'h000003);
        rd_chk("cos", OFF_COS_FLAGS, 8'h30);
        rd_chk("cos", OFF_COS_FLAGS, 8'h00);
        rd_chk("pc", OFF_PORT_C, 8'h60);
    endtask : t_cos
    task automatic t_tick;
        wr(OFF_TRIG_CMD, 8'hFD);
        wr(OFF_TRIG_EN, 8'h03);
        pulse_dac();
        chk("dac", 24'(dac_seen), 24'h000000);
        pulse_tick();
        chk("adc_n", 24'(adc_seen), 24'h000001);
        chk("dac_n", 24'(dac_seen), 24'h000001);
        chk("adc_cmd", adc_command, 24'h00001D);
        wr(OFF_TRIG_CMD, 8'h0A);
        wr(OFF_TRIG_EN, 8'h00);
        pulse_tick();
        chk("adc_n", 24'(adc_seen), 24'h000001);
        wr(OFF_TRIG_EN, 8'h02);
        pulse_tick();
        chk("adc_n", 24'(adc_seen), 24'h000002);
        chk("dac_n", 24'(dac_seen), 24'h000001);
        chk("adc_cmd", adc_command, 24'h00000A);
        pulse_dac();
        chk("dac_n", 24'(dac_seen), 24'h000002);
        wr(OFF_DAC_REF, 8'h01);
        chk("ref", dac_ref_on, 24'h000001);
    endtask : t_tick
    task automatic t_reset_again;
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        chk("ref", dac_ref_on, 24'h000000);
        chk("oe", pin_oe, 24'h000000);
        rd_chk("trig_en", OFF_TRIG_EN, 8'h00);
        rd_chk("pc", OFF_PORT_C, 8'h60);
    endtask : t_reset_again
    task automatic tally_and_finish;
        if (fail_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        t_reset_regs();
        t_ports();
        t_tristate();
        t_cos();
        t_tick();
        t_reset_again();
        tally_and_finish();
    end
endmodule : io_board_glue_registers_test
